/* File: sp_port.sv */
`timescale 1ns/1ps
// Contract
// [R01] seven bidirectional pins on bit positions 7..1, no bit 0
// [R02] unimplemented bits read zero, writes to them ignored
// [R03] direction bit clear drives latch, set makes pin a sampled input
// [R04] direction 0xce gives inputs 3..1 and 7..6, outputs 5..4
// [R05] after reset pins 6..1 are analog and their inputs read zero; code resets pins 7..1 to analog
// [R06] analog input selected disables digital input, reads zero
// [R07] output driver keeps driving latch even with analog selected
// [R08] pin7 is channel 5, pins 1..2 channels 6..7, pins 3..6 channels 8..11
// [R09] pins 3,4 second comparator inputs, pins 5,6 first comparator inputs
// [R10] routed comparator result drives pin 1 or pin 2 instead of latch
// [R11] software turns comparators off before digital input on pins 6..3
// [R12] software writes comparator off and all-digital config for full digital use
// [R13] reference output on pin 5 disables its digital driver and input
// [R14] enabled lcd segment on a pin disables every other function there
// [R15] pin 7 as input also feeds the serial slave select
// [R16] data write loads latch; latch reads latch; data reads pin levels
// [R17] peripheral overrides never change the stored direction register
module sp_port #(
	parameter int PINS = 7
) (
	// clock and reset
	input  wire logic           clk_sys_in,
	input  wire logic           sys_rst_in,
	// axi4-lite write address and data
	input  wire logic           s_awvalid_in,
	output logic                s_awready_out,
	input  wire logic [7:0]     s_awaddr_in,
	input  wire logic           s_wvalid_in,
	output logic                s_wready_out,
	input  wire logic [31:0]    s_wdata_in,
	input  wire logic [3:0]     s_wstrb_in,
	// axi4-lite write response
	output logic                s_bvalid_out,
	input  wire logic           s_bready_in,
	output logic [1:0]          s_bresp_out,
	// axi4-lite read
	input  wire logic           s_arvalid_in,
	output logic                s_arready_out,
	input  wire logic [7:0]     s_araddr_in,
	output logic                s_rvalid_out,
	input  wire logic           s_rready_in,
	output logic [31:0]         s_rdata_out,
	output logic [1:0]          s_rresp_out,
	// port pins, index = pin number
	input  wire logic [PINS:1]  pin_in,
	output logic      [PINS:1]  pin_out,
	output logic      [PINS:1]  pin_oe_out,
	// comparator results from the analog block
	input  wire logic           first_comparator_result_in,
	input  wire logic           second_comparator_result_in,
	// analog side connections
	output logic      [11:5]    converter_channel_enable_out,
	output logic      [3:0]     comparator_input_enable_out,
	output logic                comparator_reference_out_enable_out,
	output logic      [PINS:1]  lcd_segment_enable_out,
	// serial slave select, idle high
	output logic                slave_select_out
);
	import sp_pkg::*;

	// stored registers, bit 0 always zero except in the comparator and reference controls
	logic [7:0] output_latch_reg;
	logic [7:0] direction_reg;
	logic [7:0] analog_select_reg;
	logic [7:0] comparator_control;
	logic [7:0] reference_voltage_control;
	logic [7:0] segment_enable_reg;

	// bus side wires
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic       wr_lane0;
	logic       wr_hit;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       rd_hit;
	logic       wr_go;
	logic [7:0] wr_val;

	// pin side wires
	logic [PINS:1] pin_stable;
	logic [7:0]    pin_sample;
	logic [7:0]    seg_on;
	logic [7:0]    ref_on;
	logic [7:0]    cmp_in_block;
	logic [7:0]    input_enable;
	logic [7:0]    drive_enable;
	logic [7:0]    drive_value;
	logic [7:0]    pin_level_reg;
	logic          cmp_inputs_on;
	logic          route_second;
	logic          route_first;

	// keeps only the implemented bit positions
	function automatic logic [7:0] sp_impl(input logic [7:0] v);
		return v & SP_IMPL_MASK;
	endfunction

	// true when an address hits a mapped register
	function automatic logic sp_mapped(input logic [7:0] a);
		return (a == SP_OFS_LEVEL) || (a == SP_OFS_LATCH) || (a == SP_OFS_DIR) ||
			(a == SP_OFS_ANALOG) || (a == SP_OFS_CMP) || (a == SP_OFS_REF) ||
			(a == SP_OFS_SEG);
	endfunction

	sp_axil u_axil (
		.clk_sys_in   (clk_sys_in),
		.sys_rst_in   (sys_rst_in),
		.s_awvalid_in (s_awvalid_in),
		.s_awready_out(s_awready_out),
		.s_awaddr_in  (s_awaddr_in),
		.s_wvalid_in  (s_wvalid_in),
		.s_wready_out (s_wready_out),
		.s_wdata_in   (s_wdata_in),
		.s_wstrb_in   (s_wstrb_in),
		.s_bvalid_out (s_bvalid_out),
		.s_bready_in  (s_bready_in),
		.s_bresp_out  (s_bresp_out),
		.s_arvalid_in (s_arvalid_in),
		.s_arready_out(s_arready_out),
		.s_araddr_in  (s_araddr_in),
		.s_rvalid_out (s_rvalid_out),
		.s_rready_in  (s_rready_in),
		.s_rdata_out  (s_rdata_out),
		.s_rresp_out  (s_rresp_out),
		.wr_en_out    (wr_en),
		.wr_addr_out  (wr_addr),
		.wr_data_out  (wr_data),
		.wr_lane0_out (wr_lane0),
		.wr_hit_in    (wr_hit),
		.rd_addr_out  (rd_addr),
		.rd_data_in   (rd_data),
		.rd_hit_in    (rd_hit)
	);

	// pins come from the board, so they pass the three-stage filter
	sp_sync #(
		.WIDTH(PINS)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.async_in  (pin_in),
		.stable_out(pin_stable)
	);

	// write decode; byte lane 0 carries every register
	assign wr_hit = sp_mapped(wr_addr);
	assign wr_go  = wr_en && wr_lane0;
	// [R02] drop bit 0
	assign wr_val = sp_impl(wr_data);

	// control fields
	assign cmp_inputs_on = comparator_control[SP_CMP_INPUTS_BIT];
	assign route_second  = comparator_control[SP_CMP_ROUTE2_BIT];
	assign route_first   = comparator_control[SP_CMP_ROUTE1_BIT];

	// [R14] segment overrides everything on its pin
	assign seg_on = sp_impl(segment_enable_reg);

	// [R13] reference output claims pin 5
	assign ref_on = {2'h0, reference_voltage_control[SP_REF_OE_BIT], 5'h00};

	// [R11] comparator inputs on pins 6..3 block digital reads there
	assign cmp_in_block = cmp_inputs_on ? SP_CMP_IN_MASK : 8'h00;

	// digital input path: analog, comparator, reference and segment all block it
	// [R06] analog select masks the input
	// [R05] reset value of analog select makes inputs read zero
	assign input_enable = sp_impl(~analog_select_reg & ~cmp_in_block & ~ref_on & ~seg_on);

	// output driver: direction clear, no segment, no reference
	// [R03] direction zero means drive
	// [R07] analog select is deliberately absent here
	assign drive_enable = sp_impl(~direction_reg & ~seg_on & ~ref_on);

	// comparator results take priority over latch data on pins 1 and 2
	// [R10] comparator output routing
	always_comb begin
		drive_value = output_latch_reg;
		if (route_second) begin
			drive_value[SP_PIN_SECOND_RESULT] = second_comparator_result_in;
		end
		if (route_first) begin
			drive_value[SP_PIN_FIRST_RESULT] = first_comparator_result_in;
		end
	end

	// pin levels as software sees them
	assign pin_sample    = {pin_stable, 1'b0};
	// [R16] data reads sample pin levels
	assign pin_level_reg = pin_sample & input_enable;

	// read mux; unmapped addresses read zero with an error response
	assign rd_hit  = sp_mapped(rd_addr);
	assign rd_data = (rd_addr == SP_OFS_LEVEL)  ? pin_level_reg :
		(rd_addr == SP_OFS_LATCH)  ? output_latch_reg :
		(rd_addr == SP_OFS_DIR)    ? direction_reg :
		(rd_addr == SP_OFS_ANALOG) ? analog_select_reg :
		(rd_addr == SP_OFS_CMP)    ? comparator_control :
		(rd_addr == SP_OFS_REF)    ? reference_voltage_control :
		(rd_addr == SP_OFS_SEG)    ? segment_enable_reg : 8'h00;

	// [R16] data and latch offsets both load the latch
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			output_latch_reg <= SP_RST_LATCH;
		end else if (wr_go && (wr_addr == SP_OFS_LATCH || wr_addr == SP_OFS_LEVEL)) begin
			output_latch_reg <= wr_val;
		end
	end

	// direction holds only what software wrote; overrides act downstream
	// [R17] no override feedback
	// [R04] set bit means input
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			direction_reg <= SP_RST_DIR;
		end else if (wr_go && wr_addr == SP_OFS_DIR) begin
			direction_reg <= wr_val;
		end
	end

	// analog select leaves reset on, so the port starts analog
	// [R05] analog default at reset
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			analog_select_reg <= SP_RST_ANALOG;
		end else if (wr_go && wr_addr == SP_OFS_ANALOG) begin
			analog_select_reg <= wr_val;
		end
	end

	// comparator, reference and segment controls keep only their used bits
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comparator_control        <= SP_RST_CMP;
			reference_voltage_control <= SP_RST_REF;
			segment_enable_reg        <= SP_RST_SEG;
		end else if (wr_go) begin
			if (wr_addr == SP_OFS_CMP) begin
				comparator_control <= {5'h00, wr_data[2:0]};
			end
			if (wr_addr == SP_OFS_REF) begin
				reference_voltage_control <= {7'h00, wr_data[0]};
			end
			if (wr_addr == SP_OFS_SEG) begin
				segment_enable_reg <= wr_val;
			end
		end
	end

	// pin drivers registered; one cycle behind the controls
	// [R01] pins 7..1 only
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			pin_out    <= '0;
			pin_oe_out <= '0;
		end else begin
			pin_out    <= drive_value[PINS:1];
			pin_oe_out <= drive_enable[PINS:1];
		end
	end

	// [R08] pin to converter channel map, gated by segments
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			converter_channel_enable_out <= '0;
		end else begin
			converter_channel_enable_out <= {
				analog_select_reg[6:3] & ~seg_on[6:3],
				analog_select_reg[2:1] & ~seg_on[2:1],
				analog_select_reg[7] & ~seg_on[7]};
		end
	end

	// [R09] bit0 c2+ pin3, bit1 c2- pin4, bit2 c1+ pin5, bit3 c1- pin6
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comparator_input_enable_out <= '0;
		end else begin
			comparator_input_enable_out <= cmp_inputs_on ? ~seg_on[6:3] : 4'h0;
		end
	end

	// reference output and segment enables toward the analog blocks
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comparator_reference_out_enable_out <= 1'b0;
			lcd_segment_enable_out              <= '0;
		end else begin
			comparator_reference_out_enable_out <= ref_on[SP_PIN_REF] & ~seg_on[SP_PIN_REF];
			lcd_segment_enable_out              <= seg_on[PINS:1];
		end
	end

	// slave select follows pin 7 as an input; analog select does not
	// block it since it has its own buffer
	// [R15] slave select feed
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			slave_select_out <= 1'b1;
		end else if (direction_reg[SP_PIN_SS] && !seg_on[SP_PIN_SS]) begin
			slave_select_out <= pin_sample[SP_PIN_SS];
		end else begin
			slave_select_out <= 1'b1;
		end
	end
endmodule

/* File: sp_pkg.sv */
package sp_pkg;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] SP_OFS_LEVEL   = 8'h00;
	localparam logic [7:0] SP_OFS_LATCH   = 8'h04;
	localparam logic [7:0] SP_OFS_DIR     = 8'h08;
	localparam logic [7:0] SP_OFS_ANALOG  = 8'h0c;
	localparam logic [7:0] SP_OFS_CMP     = 8'h10;
	localparam logic [7:0] SP_OFS_REF     = 8'h14;
	localparam logic [7:0] SP_OFS_SEG     = 8'h18;

	// implemented bit positions: pins 7..1, bit 0 absent
	localparam logic [7:0] SP_IMPL_MASK   = 8'hfe;

	// reset values
	localparam logic [7:0] SP_RST_LATCH   = 8'h00;
	localparam logic [7:0] SP_RST_DIR     = 8'hfe;
	localparam logic [7:0] SP_RST_ANALOG  = 8'hfe;
	localparam logic [7:0] SP_RST_CMP     = 8'h01;
	localparam logic [7:0] SP_RST_REF     = 8'h00;
	localparam logic [7:0] SP_RST_SEG     = 8'h00;

	// field positions of the comparator and reference controls
	localparam int SP_CMP_INPUTS_BIT = 0;
	localparam int SP_CMP_ROUTE2_BIT = 1;
	localparam int SP_CMP_ROUTE1_BIT = 2;
	localparam int SP_REF_OE_BIT     = 0;

	// pins with special functions
	localparam int SP_PIN_SECOND_RESULT = 1;
	localparam int SP_PIN_FIRST_RESULT  = 2;
	localparam int SP_PIN_REF   = 5;
	localparam int SP_PIN_SS    = 7;
	localparam logic [7:0] SP_CMP_IN_MASK = 8'h78;

	// axi responses
	localparam logic [1:0] SP_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SP_RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		SP_CH_IDLE = 1'b0,
		SP_CH_BUSY = 1'b1
	} sp_chan_e;

endpackage

/* File: sp_sync.sv */
`timescale 1ns/1ps
module sp_sync #(
	parameter int WIDTH = 7
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             sys_rst_in,
	// asynchronous levels in, filtered levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] stable_out
);
	logic [WIDTH-1:0] ff1;
	logic [WIDTH-1:0] ff2;
	logic [WIDTH-1:0] ff3;
	logic [WIDTH-1:0] next_stable;

	// a bit changes only once stages two and three agree
	assign next_stable = (ff2 & ff3) | (stable_out & (ff2 | ff3));

	// three-stage chain; ff1 feeds ff2 only
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ff1        <= '0;
			ff2        <= '0;
			ff3        <= '0;
			stable_out <= '0;
		end else begin
			ff1        <= async_in;
			ff2        <= ff1;
			ff3        <= ff2;
			stable_out <= next_stable;
		end
	end
endmodule

/* File: sp_axil.sv */
`timescale 1ns/1ps
module sp_axil (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        sys_rst_in,
	// write address and data
	input  wire logic        s_awvalid_in,
	output logic             s_awready_out,
	input  wire logic [7:0]  s_awaddr_in,
	input  wire logic        s_wvalid_in,
	output logic             s_wready_out,
	input  wire logic [31:0] s_wdata_in,
	input  wire logic [3:0]  s_wstrb_in,
	// write response
	output logic             s_bvalid_out,
	input  wire logic        s_bready_in,
	output logic [1:0]       s_bresp_out,
	// read address and data
	input  wire logic        s_arvalid_in,
	output logic             s_arready_out,
	input  wire logic [7:0]  s_araddr_in,
	output logic             s_rvalid_out,
	input  wire logic        s_rready_in,
	output logic [31:0]      s_rdata_out,
	output logic [1:0]       s_rresp_out,
	// register side
	output logic             wr_en_out,
	output logic [7:0]       wr_addr_out,
	output logic [7:0]       wr_data_out,
	output logic             wr_lane0_out,
	input  wire logic        wr_hit_in,
	output logic [7:0]       rd_addr_out,
	input  wire logic [7:0]  rd_data_in,
	input  wire logic        rd_hit_in
);
	import sp_pkg::*;

	sp_chan_e aw_state;
	sp_chan_e w_state;
	logic     aw_take;
	logic     w_take;
	logic     ar_take;
	logic     wr_fire;

	// write channels are taken while their holding slot is free and no response waits; read while no read data waits
	assign s_awready_out = (aw_state == SP_CH_IDLE) && !s_bvalid_out;
	assign s_wready_out  = (w_state == SP_CH_IDLE) && !s_bvalid_out;
	assign s_arready_out = !s_rvalid_out;
	assign aw_take       = s_awvalid_in && s_awready_out;
	assign w_take        = s_wvalid_in && s_wready_out;
	assign ar_take       = s_arvalid_in && s_arready_out;
	assign wr_fire       = (aw_state == SP_CH_BUSY) && (w_state == SP_CH_BUSY) && !s_bvalid_out;
	assign wr_en_out     = wr_fire;
	assign rd_addr_out   = s_araddr_in;

	// address and data are held until both have arrived, in either order
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			aw_state     <= SP_CH_IDLE;
			w_state      <= SP_CH_IDLE;
			wr_addr_out  <= '0;
			wr_data_out  <= '0;
			wr_lane0_out <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_state    <= SP_CH_BUSY;
				wr_addr_out <= s_awaddr_in;
			end else if (wr_fire) begin
				aw_state <= SP_CH_IDLE;
			end
			if (w_take) begin
				w_state      <= SP_CH_BUSY;
				wr_data_out  <= s_wdata_in[7:0];
				wr_lane0_out <= s_wstrb_in[0];
			end else if (wr_fire) begin
				w_state <= SP_CH_IDLE;
			end
		end
	end

	// write response raised on the same edge that the write lands
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			s_bvalid_out <= 1'b0;
			s_bresp_out  <= SP_RESP_OKAY;
		end else if (wr_fire) begin
			s_bvalid_out <= 1'b1;
			s_bresp_out  <= wr_hit_in ? SP_RESP_OKAY : SP_RESP_SLVERR;
		end else if (s_bready_in) begin
			s_bvalid_out <= 1'b0;
		end
	end

	// read data captured at the address handshake, upper bits zero
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			s_rvalid_out <= 1'b0;
			s_rdata_out  <= '0;
			s_rresp_out  <= SP_RESP_OKAY;
		end else if (ar_take) begin
			s_rvalid_out <= 1'b1;
			s_rdata_out  <= {24'h000000, rd_data_in};
			s_rresp_out  <= rd_hit_in ? SP_RESP_OKAY : SP_RESP_SLVERR;
		end else if (s_rready_in) begin
			s_rvalid_out <= 1'b0;
		end
	end
endmodule

/* File: sp_port_monitor.sv */
`timescale 1ns/1ps
module sp_port_monitor #(
	parameter int PINS = 7
) (
	// clock and reset
	input wire logic          clk_sys_in,
	input wire logic          sys_rst_in,
	// register bus
	input wire logic          s_awvalid_in,
	input wire logic          s_awready_out,
	input wire logic          s_wvalid_in,
	input wire logic          s_wready_out,
	input wire logic          s_bvalid_out,
	input wire logic          s_bready_in,
	input wire logic [1:0]    s_bresp_out,
	input wire logic          s_arvalid_in,
	input wire logic          s_arready_out,
	input wire logic          s_rvalid_out,
	input wire logic          s_rready_in,
	input wire logic [31:0]   s_rdata_out,
	// pin and analog side
	input wire logic [PINS:1] pin_oe_out,
	input wire logic [PINS:1] lcd_segment_enable_out,
	input wire logic [11:5]   converter_channel_enable_out,
	input wire logic          comparator_reference_out_enable_out,
	input wire logic          slave_select_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	// handshake steps of a register access
	sequence aw_taken;
		s_awvalid_in && s_awready_out;
	endsequence
	sequence w_taken;
		s_wvalid_in && s_wready_out;
	endsequence
	sequence ar_taken;
		s_arvalid_in && s_arready_out;
	endsequence

	chk_write_answer: assert property (aw_taken and w_taken |-> ##2 s_bvalid_out)
		else $error("write response not two edges after both handshakes");
	chk_bresp_hold: assert property (s_bvalid_out && !s_bready_in |=> s_bvalid_out && $stable(s_bresp_out))
		else $error("write response dropped before bready");
	chk_write_block: assert property (s_bvalid_out |-> !s_awready_out && !s_wready_out)
		else $error("write accepted while response pending");
	chk_read_answer: assert property (ar_taken |=> s_rvalid_out)
		else $error("read data not one edge after address");
	chk_rdata_hold: assert property (s_rvalid_out && !s_rready_in |=> s_rvalid_out && $stable(s_rdata_out))
		else $error("read data changed before rready");
	chk_read_block: assert property (s_rvalid_out |-> !s_arready_out)
		else $error("read accepted while data pending");
	chk_upper_zero: assert property (s_rvalid_out |-> s_rdata_out[31:8] == 24'h0)
		else $error("unused read bits not zero");
	chk_ref_drive: assert property (comparator_reference_out_enable_out |-> !pin_oe_out[5])
		else $error("pin five driven with reference out");
	chk_seg_drive: assert property ((lcd_segment_enable_out & pin_oe_out) == '0)
		else $error("pin driven while its segment is on");
	// reset leaves all pins undriven, then analog on every channel
	chk_reset_state: assert property ($fell(sys_rst_in) |-> pin_oe_out == '0 && slave_select_out
		##1 converter_channel_enable_out == 7'h7f)
		else $error("state after reset wrong");
endmodule

bind sp_port sp_port_monitor #(.PINS(PINS)) mon (
	.clk_sys_in, .sys_rst_in, .s_awvalid_in, .s_awready_out, .s_wvalid_in, .s_wready_out,
	.s_bvalid_out, .s_bready_in, .s_bresp_out, .s_arvalid_in, .s_arready_out, .s_rvalid_out,
	.s_rready_in, .s_rdata_out, .pin_oe_out, .lcd_segment_enable_out,
	.converter_channel_enable_out, .comparator_reference_out_enable_out, .slave_select_out
);

/* File: sp_pad_model.sv */
`timescale 1ns/1ps
module sp_pad_model (
	// port side of each pad
	input  wire logic [7:1] pin_out_in,
	input  wire logic [7:1] pin_oe_in,
	// board drive and resolved pad level
	input  wire logic [7:1] board_level_in,
	output logic      [7:1] pin_level_out
);
	// the port wins where it drives; the board resistors set the rest
	assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & board_level_in);
endmodule

/* File: sp_port_test.sv */
`timescale 1ns/1ps
module sp_port_test;
	import sp_pkg::*;
	// clock, reset, comparator results
	logic        clk_sys_in, sys_rst_in;
	logic        first_comparator_result_in, second_comparator_result_in;
	// register bus
	logic        s_awvalid_in, s_wvalid_in, s_bready_in, s_arvalid_in, s_rready_in;
	logic [7:0]  s_awaddr_in, s_araddr_in;
	logic [31:0] s_wdata_in, s_rdata_out;
	logic [3:0]  s_wstrb_in;
	logic        s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
	logic [1:0]  s_bresp_out, s_rresp_out;
	// pins and analog side
	logic [7:1]  pin_in, pin_out, pin_oe_out, lcd_segment_enable_out, board_level;
	logic [11:5] converter_channel_enable_out;
	logic [3:0]  comparator_input_enable_out;
	logic        comparator_reference_out_enable_out, slave_select_out;
	int          err_count, comparisons;

	sp_port #(.PINS(7)) dut (
		.clk_sys_in, .sys_rst_in, .s_awvalid_in, .s_awready_out, .s_awaddr_in, .s_wvalid_in,
		.s_wready_out, .s_wdata_in, .s_wstrb_in, .s_bvalid_out, .s_bready_in, .s_bresp_out,
		.s_arvalid_in, .s_arready_out, .s_araddr_in, .s_rvalid_out, .s_rready_in, .s_rdata_out,
		.s_rresp_out, .pin_in, .pin_out, .pin_oe_out, .first_comparator_result_in,
		.second_comparator_result_in, .converter_channel_enable_out, .comparator_input_enable_out,
		.comparator_reference_out_enable_out, .lcd_segment_enable_out, .slave_select_out
	);
	sp_pad_model pads (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .board_level_in(board_level),
		.pin_level_out(pin_in));

	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	// address and data go out together; each is dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit done;
		done = 1'b0;
		@(posedge clk_sys_in);
		s_awvalid_in <= 1'b1;
		s_awaddr_in <= a;
		s_wvalid_in <= 1'b1;
		s_wdata_in <= d;
		s_bready_in <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(posedge clk_sys_in);
			if (s_awready_out) s_awvalid_in <= 1'b0;
			if (s_wready_out) s_wvalid_in <= 1'b0;
			if (s_bvalid_out) begin
				check(s_bresp_out, er);
				s_bready_in <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			err_count++;
			finish_test();
		end
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit done;
		done = 1'b0;
		@(posedge clk_sys_in);
		s_arvalid_in <= 1'b1;
		s_araddr_in <= a;
		s_rready_in <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(posedge clk_sys_in);
			if (s_arready_out) s_arvalid_in <= 1'b0;
			if (s_rvalid_out) begin
				check(s_rdata_out, ed);
				check(s_rresp_out, er);
				s_rready_in <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			err_count++;
			finish_test();
		end
	endtask

	// expected data read: inputs show the board, outputs read their own pad back
	function automatic logic [31:0] lvl(input logic [7:0] dir, input logic [7:0] lat,
		input logic [7:0] en);
		return {24'h0, ((({board_level, 1'b0}) & dir) | (lat & ~dir)) & en & 8'hfe};
	endfunction

	task automatic sc_reset;
		axi_read(SP_OFS_LATCH, 32'h0, SP_RESP_OKAY);
		axi_read(SP_OFS_DIR, 32'hfe, SP_RESP_OKAY);
		axi_read(SP_OFS_ANALOG, 32'hfe, SP_RESP_OKAY);
		axi_read(SP_OFS_CMP, 32'h01, SP_RESP_OKAY);
		axi_read(SP_OFS_LEVEL, 32'h0, SP_RESP_OKAY);
		check(converter_channel_enable_out, 32'h7f);
		check(comparator_input_enable_out, 32'hf);
		check(pin_oe_out, 32'h0);
	endtask

	task automatic sc_digital;
		axi_write(SP_OFS_CMP, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_ANALOG, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_LATCH, 32'hffff_ff31, SP_RESP_OKAY);
		axi_write(SP_OFS_DIR, 32'hcf, SP_RESP_OKAY);
		board_level <= 7'h53;
		settle(8);
		check(pin_oe_out, 32'h18);
		check(pin_out, 32'h18);
		axi_read(SP_OFS_DIR, 32'hce, SP_RESP_OKAY);
		axi_read(SP_OFS_LATCH, 32'h30, SP_RESP_OKAY);
		axi_read(SP_OFS_LEVEL, lvl(8'hce, 8'h30, 8'hfe), SP_RESP_OKAY);
		axi_write(SP_OFS_LEVEL, 32'h20, SP_RESP_OKAY);
		axi_read(SP_OFS_LATCH, 32'h20, SP_RESP_OKAY);
		s_wstrb_in <= 4'he;
		axi_write(SP_OFS_LATCH, 32'h0, SP_RESP_OKAY);
		s_wstrb_in <= 4'hf;
		axi_read(SP_OFS_LATCH, 32'h20, SP_RESP_OKAY);
		axi_write(8'h1c, 32'h1, SP_RESP_SLVERR);
		axi_read(8'h1c, 32'h0, SP_RESP_SLVERR);
	endtask

	// analog select against output drive and channel map
	task automatic sc_analog;
		axi_write(SP_OFS_DIR, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_ANALOG, 32'hfe, SP_RESP_OKAY);
		settle(8);
		check(pin_oe_out, 32'h7f);
		check(pin_out, 32'h10);
		axi_read(SP_OFS_LEVEL, 32'h0, SP_RESP_OKAY);
		for (int p = 1; p <= 7; p++) begin
			axi_write(SP_OFS_ANALOG, 32'h1 << p, SP_RESP_OKAY);
			settle(2);
			check(converter_channel_enable_out, 32'h1 << (p == 7 ? 0 : p));
		end
		axi_write(SP_OFS_ANALOG, 32'h0, SP_RESP_OKAY);
	endtask

	task automatic sc_comparator;
		axi_write(SP_OFS_LATCH, 32'h06, SP_RESP_OKAY);
		axi_write(SP_OFS_CMP, 32'h06, SP_RESP_OKAY);
		settle(2);
		check(comparator_input_enable_out, 32'h0);
		for (int c = 0; c < 4; c++) begin
			first_comparator_result_in <= c[0];
			second_comparator_result_in <= c[1];
			settle(4);
			check(pin_out[2], c[0]);
			check(pin_out[1], c[1]);
		end
		axi_write(SP_OFS_DIR, 32'hfe, SP_RESP_OKAY);
		axi_write(SP_OFS_CMP, 32'h01, SP_RESP_OKAY);
		board_level <= 7'h7f;
		settle(8);
		check(comparator_input_enable_out, 32'hf);
		axi_read(SP_OFS_LEVEL, 32'h86, SP_RESP_OKAY);
		axi_write(SP_OFS_CMP, 32'h0, SP_RESP_OKAY);
		axi_read(SP_OFS_LEVEL, 32'hfe, SP_RESP_OKAY);
	endtask

	task automatic sc_override;
		axi_write(SP_OFS_LATCH, 32'h20, SP_RESP_OKAY);
		axi_write(SP_OFS_DIR, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_REF, 32'h1, SP_RESP_OKAY);
		settle(8);
		check(comparator_reference_out_enable_out, 32'h1);
		check(pin_oe_out, 32'h6f);
		axi_read(SP_OFS_LEVEL, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_REF, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_SEG, 32'hff, SP_RESP_OKAY);
		settle(8);
		check(lcd_segment_enable_out, 32'h7f);
		check(pin_oe_out, 32'h0);
		check(slave_select_out, 32'h1);
		axi_read(SP_OFS_SEG, 32'hfe, SP_RESP_OKAY);
		axi_read(SP_OFS_DIR, 32'h0, SP_RESP_OKAY);
		axi_read(SP_OFS_LEVEL, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_SEG, 32'h0, SP_RESP_OKAY);
		axi_write(SP_OFS_DIR, 32'hfe, SP_RESP_OKAY);
		board_level <= 7'h3f;
		settle(8);
		check(slave_select_out, 32'h0);
		board_level <= 7'h7f;
		settle(8);
		check(slave_select_out, 32'h1);
	endtask

	initial begin
		sys_rst_in = 1'b1;
		{s_awvalid_in, s_wvalid_in, s_bready_in, s_arvalid_in, s_rready_in} = 5'h0;
		{s_awaddr_in, s_araddr_in, s_wdata_in} = 48'h0;
		s_wstrb_in = 4'hf;
		first_comparator_result_in = 1'b0;
		second_comparator_result_in = 1'b0;
		board_level = 7'h7f;
		err_count = 0;
		comparisons = 0;
		settle(12);
		sys_rst_in <= 1'b0;
		settle(8);
		sc_reset();
		sc_digital();
		sc_analog();
		sc_comparator();
		sc_override();
		finish_test();
	end
endmodule
